// ### hw/sod_list_writer.v
/*
 host-side builder of display-list orders for the raster engine: takes one
 order request, packs it into words, and writes them to memory one word per
 handshake; also writes runs-table terminator words on request.
 assumes the memory write port accepts a word when mem_ack is high while
 mem_wr is high, and that the raster engine reports completion on done_evt.
 the caller sends the logic-op and tile-size orders itself; this block only
 checks what it can see in one request, so a tile larger than the one the
 engine was given is not caught here.
*/
`include "sod_regs.vh"

// Contract
// - runs to frame: 14, 00, addr, pitch, table
// - table pointer names first specifier, not terminator
// - table pointer 28 bits, word aligned
// - tiled frame order 15 with full packet
// - tile dimensions configured before tiled orders
// - remainders between one and tile size
// - upper-left start uses width and height
// - both table pointers word aligned, first specifier
// - runs to unbanded 24, no pitch word
// - tiled unbanded 25, no pitch word
// - every list ends with stop 00 00
module sod_list_writer (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire req,
	input wire [2:0] kind,
	input wire [31:0] dest_bit_addr,
	input wire [15:0] frame_pitch_bits,
	input wire [15:0] unbanded_pitch_bits,
	input wire [15:0] tile_x_remaining,
	input wire [15:0] tile_y_remaining,
	input wire [15:0] tile_width,
	input wire [15:0] tile_height,
	input wire [31:0] tile_start_addr,
	input wire [31:0] tile_run_table_ptr,
	input wire [31:0] run_table_ptr,
	input wire [27:0] list_base,
	input wire mem_ack,
	input wire done_evt,
	output reg busy,
	output reg req_err,
	output reg mem_wr,
	output reg [27:0] mem_addr,
	output reg [15:0] mem_wdata,
	output reg list_done
);
	// sequencer states: take a request, stage its words, write them, settle
	localparam ST_IDLE = 2'h0;
	localparam ST_LOAD = 2'h1;
	localparam ST_SEND = 2'h2;
	localparam ST_WAIT = 2'h3;

	// sequencer and staging-store bookkeeping
	reg [1:0] state;
	reg [1:0] next_state;
	reg [3:0] wr_idx;
	reg [3:0] rd_idx;
	reg [3:0] count;
	reg [3:0] sent;
	reg [27:0] list_ptr;
	reg started;
	reg stopped;
	reg [15:0] load_word;
	reg load_en;
	reg [3:0] pkt_len;
	reg pkt_ok;
	reg rd_valid;
	wire [15:0] rd_data;

	// word-aligned 28-bit pointer kept as the engine reads it
	function [31:0] sod_ptr;
		input [31:0] p;
		begin
			sod_ptr = p & `SOD_PTR_MASK;
		end
	endfunction

	// range check: 1 <= rem <= size
	function sod_in_range;
		input [15:0] rem;
		input [15:0] size;
		begin
			sod_in_range = (rem != 16'h0000) && (rem <= size);
		end
	endfunction

	// an order's first word: opcode in the high byte, reserved byte below
	function [15:0] sod_op_word;
		input [7:0] op;
		begin
			sod_op_word = {op, `SOD_OP_RESERVED};
		end
	endfunction

	// true when idx names the final word of a packet of len words
	function sod_is_last;
		input [3:0] idx;
		input [3:0] len;
		begin
			sod_is_last = (idx == len - 4'h1);
		end
	endfunction

	// masked pointers as the engine will fetch them
	wire [31:0] run_ptr_masked;
	wire [31:0] tile_ptr_masked;
	assign run_ptr_masked = sod_ptr(run_table_ptr);
	assign tile_ptr_masked = sod_ptr(tile_run_table_ptr);

	// length of each packet in 16-bit words
	always @* begin
		case (kind)
		`SOD_KIND_RUNS_FRAME: pkt_len = 4'h6;
		`SOD_KIND_TILED_FRAME: pkt_len = 4'hC;
		`SOD_KIND_RUNS_UNB: pkt_len = 4'h5;
		`SOD_KIND_TILED_UNB: pkt_len = 4'hB;
		`SOD_KIND_STOP: pkt_len = 4'h1;
		`SOD_KIND_LAYOUT: pkt_len = 4'h2;
		default: pkt_len = 4'h1; // lone terminator word
		endcase
	end

	// tiled orders are refused with bad remainders; runs and tiled orders with a zero run table pointer
	always @* begin
		pkt_ok = 1'b1;
		if (kind == `SOD_KIND_TILED_FRAME || kind == `SOD_KIND_TILED_UNB) begin
			pkt_ok = sod_in_range(tile_x_remaining, tile_width) &&
				sod_in_range(tile_y_remaining, tile_height);
		end
		// a zero run table pointer would send the engine to the terminator, or to
		// nothing at all, so it is caught here rather than rendered as garbage
		if (kind <= `SOD_KIND_TILED_UNB && run_ptr_masked == 32'h00000000) begin
			pkt_ok = 1'b0;
		end
	end

	// word sequence of the packet at index wr_idx
	always @* begin
		load_word = `SOD_TERM_WORD;
		case (kind)
		`SOD_KIND_RUNS_FRAME, `SOD_KIND_RUNS_UNB: begin
			case (wr_idx)
			4'h0: load_word = sod_op_word((kind == `SOD_KIND_RUNS_FRAME) ?
				`SOD_OP_RUNS_FRAME : `SOD_OP_RUNS_UNB);
			4'h1: load_word = dest_bit_addr[31:16];
			4'h2: load_word = dest_bit_addr[15:0];
			4'h3: load_word = (kind == `SOD_KIND_RUNS_FRAME) ? frame_pitch_bits :
				run_ptr_masked[31:16];
			4'h4: load_word = (kind == `SOD_KIND_RUNS_FRAME) ?
				run_ptr_masked[31:16] : run_ptr_masked[15:0];
			default: load_word = run_ptr_masked[15:0];
			endcase
		end
		`SOD_KIND_TILED_FRAME, `SOD_KIND_TILED_UNB: begin
			// the unbanded form skips the pitch word, so shift the index past it
			case ((kind == `SOD_KIND_TILED_UNB && wr_idx >= 4'h3) ? wr_idx + 4'h1 : wr_idx)
			4'h0: load_word = sod_op_word((kind == `SOD_KIND_TILED_FRAME) ?
				`SOD_OP_TILED_FRAME : `SOD_OP_TILED_UNB);
			4'h1: load_word = dest_bit_addr[31:16];
			4'h2: load_word = dest_bit_addr[15:0];
			4'h3: load_word = frame_pitch_bits;
			4'h4: load_word = tile_x_remaining;
			4'h5: load_word = tile_y_remaining;
			4'h6: load_word = tile_start_addr[31:16];
			4'h7: load_word = tile_start_addr[15:0];
			4'h8: load_word = tile_ptr_masked[31:16];
			4'h9: load_word = tile_ptr_masked[15:0];
			4'hA: load_word = run_ptr_masked[31:16];
			default: load_word = run_ptr_masked[15:0];
			endcase
		end
		`SOD_KIND_STOP: load_word = sod_op_word(`SOD_OP_STOP);
		`SOD_KIND_LAYOUT: load_word = (wr_idx == 4'h0) ?
			sod_op_word(`SOD_OP_SET_LAYOUT) : unbanded_pitch_bits;
		default: load_word = `SOD_TERM_WORD;
		endcase
	end

	// the store is written only while a packet is being staged
	always @* begin
		load_en = (state == ST_LOAD);
	end

	// the packet is staged whole before the first write; each word is taken from
	// the request fields in its own load cycle and stays fixed while it is sent
	sod_word_mem u_mem (
		.clk(clk),
		.ce(ce),
		.wr_en(load_en),
		.wr_idx(wr_idx),
		.wr_data(load_word),
		.rd_idx(rd_idx),
		.rd_data(rd_data)
	);

	// order sequencer
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: if (req && !stopped && pkt_ok) next_state = ST_LOAD;
		ST_LOAD: if (sod_is_last(wr_idx, count)) next_state = ST_SEND;
		ST_SEND: if (mem_wr && mem_ack && sod_is_last(sent, count)) next_state = ST_WAIT;
		ST_WAIT: next_state = ST_IDLE;
		default: next_state = ST_IDLE;
		endcase
	end

	// dest and tile logic ops must be sent by the caller beforehand
	always @(posedge clk) begin
		if (reset) begin
			// outputs all clear so the memory sees no write out of reset
			state <= ST_IDLE;
			wr_idx <= 4'h0;
			rd_idx <= 4'h0;
			count <= 4'h0;
			sent <= 4'h0;
			list_ptr <= 28'h0000000;
			started <= 1'b0;
			stopped <= 1'b0;
			rd_valid <= 1'b0;
			busy <= 1'b0;
			req_err <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= 28'h0000000;
			mem_wdata <= 16'h0000;
			list_done <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			req_err <= 1'b0;
			list_done <= 1'b0;
			case (state)
			ST_IDLE: begin
				wr_idx <= 4'h0;
				rd_idx <= 4'h0;
				sent <= 4'h0;
				count <= pkt_len;
				req_err <= req && (stopped || !pkt_ok);
				busy <= req && !stopped && pkt_ok;
				// a new list starts at the base; within a list the pointer only moves on
				if (!started) begin
					list_ptr <= list_base & 28'hFFFFFFE;
				end
			end
			ST_LOAD: begin
				wr_idx <= wr_idx + 4'h1;
				if (sod_is_last(wr_idx, count)) begin
					rd_valid <= 1'b0; // word 0 is fetched in the first send cycle
				end
			end
			ST_SEND: begin
				// memory read has one cycle of latency; present each word once it lands.
				// a one-word packet is written and read in the same cycle, so the
				// first send cycle only fetches word 0 and points at word 1
				if (!rd_valid) begin
					rd_valid <= 1'b1;
					rd_idx <= 4'h1;
				end else if (!mem_wr) begin
					mem_wr <= 1'b1;
					mem_addr <= list_ptr;
					mem_wdata <= rd_data;
				end else if (mem_ack) begin
					sent <= sent + 4'h1;
					list_ptr <= list_ptr + 28'h0000002;
					mem_wr <= 1'b0;
					rd_idx <= rd_idx + 4'h1;
					if (sod_is_last(sent, count)) begin
						started <= 1'b1;
						stopped <= (kind == `SOD_KIND_STOP);
					end
				end
			end
			ST_WAIT: begin
				// one settling cycle: busy falls only after the last word is taken
				busy <= 1'b0;
			end
			default: busy <= 1'b0;
			endcase
			// engine halts at the stop order; the list may be rebuilt afterwards
			// a done event with no stop outstanding is ignored
			if (done_evt && stopped) begin
				list_done <= 1'b1;
				stopped <= 1'b0;
				started <= 1'b0;
			end
		end
	end
endmodule

// ### hw/sod_regs.vh
/*
 holds opcodes, order kinds, the pointer mask, word widths and buffer sizes for the display-list writer.
 assumes a memory that stores 16-bit words, big-endian byte order within each word.
*/
`ifndef SOD_REGS_VH
`define SOD_REGS_VH
`define SOD_OP_STOP 8'h00
`define SOD_OP_RESERVED 8'h00
`define SOD_OP_SET_LAYOUT 8'h09
`define SOD_OP_RUNS_FRAME 8'h14
`define SOD_OP_TILED_FRAME 8'h15
`define SOD_OP_RUNS_UNB 8'h24
`define SOD_OP_TILED_UNB 8'h25
`define SOD_KIND_RUNS_FRAME 3'h0
`define SOD_KIND_TILED_FRAME 3'h1
`define SOD_KIND_RUNS_UNB 3'h2
`define SOD_KIND_TILED_UNB 3'h3
`define SOD_KIND_STOP 3'h4
`define SOD_KIND_LAYOUT 3'h5
`define SOD_PTR_MASK 32'h0FFFFFFE
`define SOD_TERM_WORD 16'h0000
`define SOD_ADDR_W 28
`define SOD_WORD_W 16
`define SOD_BUF_DEPTH 16
`define SOD_BUF_AW 4
`endif

// ### hw/sod_word_mem.v
/*
 little staging memory holding the words of one order packet before they are written out.
 assumes one write and one read port in the same clock; read data are registered.
*/
`include "sod_regs.vh"
module sod_word_mem (
	input wire clk,
	input wire ce,
	input wire wr_en,
	input wire [`SOD_BUF_AW-1:0] wr_idx,
	input wire [`SOD_WORD_W-1:0] wr_data,
	input wire [`SOD_BUF_AW-1:0] rd_idx,
	output reg [`SOD_WORD_W-1:0] rd_data
);
	reg [`SOD_WORD_W-1:0] mem [0:`SOD_BUF_DEPTH-1];

	// no reset on the array: contents are always written before they are read
	always @(posedge clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_idx] <= wr_data;
			end
			rd_data <= mem[rd_idx];
		end
	end
endmodule

// ### verification/sod_list_writer_sva.sv
/*
 port assertions for the list writer.
 assumes the bench binds it to the top and drops ce only while idle.
*/
module sod_list_writer_sva (
	input wire clk,
	input wire reset,
	input wire mem_ack,
	input wire done_evt,
	input wire busy,
	input wire req_err,
	input wire mem_wr,
	input wire [27:0] mem_addr,
	input wire [15:0] mem_wdata,
	input wire list_done
);
	logic [27:0] nxt;
	logic seen;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// address the next word must take
	always @(posedge clk) begin
		if (reset) seen <= 1'b0;
		else if (mem_wr && mem_ack) seen <= 1'b1;
		else if (list_done) seen <= 1'b0; // a finished list restarts at its base
		if (mem_wr && mem_ack) nxt <= mem_addr + 28'h2;
	end
	AST_HOLD: assert property (mem_wr && !mem_ack |=> mem_wr && $stable(mem_addr)
		&& $stable(mem_wdata)) else $error("write dropped before ack");
	AST_ACK_DROP: assert property (mem_wr && mem_ack |=> !mem_wr)
		else $error("write held after ack");
	AST_NEXT: assert property ($rose(mem_wr) && seen |-> mem_addr == nxt)
		else $error("word not at next address");
	AST_ALIGN: assert property (mem_wr |-> !mem_addr[0])
		else $error("odd word address");
	AST_WR_BUSY: assert property (mem_wr |-> busy)
		else $error("write while idle");
	AST_ERR_PULSE: assert property (req_err |=> !req_err)
		else $error("refusal not a pulse");
	AST_DONE_PULSE: assert property (list_done |=> !list_done)
		else $error("done not a pulse");
	AST_DONE_CAUSE: assert property (list_done |-> $past(done_evt) || $past(done_evt, 2))
		else $error("done without engine event");
endmodule

// ### verification/sod_mem_model.sv
/*
 memory and raster engine model: stores written words, decodes each opcode
 word and raises done_evt after a stop. assumes one clock, sync reset.
*/
module sod_mem_model (
	input wire clk,
	input wire reset,
	input wire slow,
	input wire mem_wr,
	input wire [27:0] mem_addr,
	input wire [15:0] mem_wdata,
	output wire mem_ack,
	output reg done_evt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:255];
	logic [1:0] w;
	int left;
	int dly;
	// slow mode stalls every word three cycles
	assign mem_ack = mem_wr && (!slow || w == 2'h3);
	// skip each order's parameters, a stop ends the list
	always @(posedge clk) begin
		w <= (mem_wr && !mem_ack) ? w + 2'h1 : 2'h0;
		done_evt <= dly == 1;
		if (dly > 0) dly <= dly - 1;
		if (reset) begin
			left <= 0;
			dly <= 0;
		end else if (mem_wr && mem_ack) begin
			mem[mem_addr[8:1]] <= mem_wdata;
			if (left > 0) left <= left - 1;
			else case (mem_wdata[15:8])
			8'h14: left <= 5;
			8'h15: left <= 11;
			8'h24: left <= 4;
			8'h25: left <= 10;
			8'h09: left <= 1;
			default: dly <= 20;
			endcase
		end
	end
endmodule

// ### verification/tb.sv
/*
 bench for the list writer: run issues one order and compares the words
 the memory model captured; refuse checks req_err and busy, t_freeze checks busy only. assumes a fixed list base; ce drops only in
 the freeze scenario.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, req = 0, slow = 0, ce = 1;
	logic [2:0] kind = 3'h0;
	logic [31:0] dest = 32'h12345678, tile_addr = 32'h00ABCDEF, tile_tab = 32'h00002000;
	logic [31:0] run_tab = 32'hF0001235;
	logic [15:0] pitch = 16'h0140, upw = 16'h0280, xr = 16'h0008, yr = 16'h0004;
	logic [15:0] tile_w = 16'h0008, tile_h = 16'h0004; // set before any tiled order
	wire busy, req_err, mem_wr, mem_ack, done_evt, list_done;
	wire [27:0] mem_addr;
	wire [15:0] mem_wdata;
	int bad_count = 0, num_checks = 0, idx = 128, cyc = 0;
	always #5 clk = ~clk;
	sod_list_writer i_dut (.clk(clk), .reset(reset), .ce(ce), .req(req), .kind(kind),
		.dest_bit_addr(dest), .frame_pitch_bits(pitch), .unbanded_pitch_bits(upw),
		.tile_x_remaining(xr), .tile_y_remaining(yr), .tile_width(tile_w),
		.tile_height(tile_h), .tile_start_addr(tile_addr), .tile_run_table_ptr(tile_tab),
		.run_table_ptr(run_tab), .list_base(28'h0000100), .mem_ack(mem_ack),
		.done_evt(done_evt), .busy(busy), .req_err(req_err), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .list_done(list_done));
	sod_mem_model i_mem (.clk(clk), .reset(reset), .slow(slow), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .done_evt(done_evt));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one order, then compare the words it left in memory
	task run(input logic [2:0] k, input logic [15:0] w[$]);
		@(posedge clk);
		kind <= k;
		req <= 1'b1;
		repeat (20) if (busy !== 1'b1) @(negedge clk);
		@(posedge clk);
		req <= 1'b0;
		repeat (300) if (busy !== 1'b0) @(negedge clk);
		foreach (w[i]) chk(i_mem.mem[idx + i], w[i]);
		idx += w.size();
	endtask
	// a refused order pulses req_err once and never goes busy
	task refuse(input logic [2:0] k, input logic [15:0] x, input logic [31:0] s);
		int n;
		n = 0;
		@(posedge clk);
		{kind, xr, run_tab, req} <= {k, x, s, 1'b1};
		@(posedge clk);
		{xr, run_tab, req} <= {16'h0008, 32'hF0001235, 1'b0};
		repeat (4) begin
			@(negedge clk);
			if (req_err === 1'b1) n++;
		end
		chk(16'(n), 16'h0001);
		chk({15'h0, busy}, 16'h0000);
	endtask
	// with ce low a pending request must not be taken
	task t_freeze;
		@(posedge clk);
		{ce, kind, req} <= {1'b0, 3'h0, 1'b1};
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({15'h0, busy}, 16'h0000);
		@(posedge clk);
		{ce, req} <= {1'b1, 1'b0};
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({15'h0, busy}, 16'h0000);
	endtask
	task t_frame;
		run(3'h0, '{16'h1400, 16'h1234, 16'h5678, 16'h0140, 16'h0000, 16'h1234});
		run(3'h6, '{16'h0000});
	endtask
	task t_tiled;
		slow = 1'b1;
		run(3'h1, '{16'h1500, 16'h1234, 16'h5678, 16'h0140, 16'h0008, 16'h0004, 16'h00AB, 16'hCDEF, 16'h0000, 16'h2000, 16'h0000, 16'h1234});
		slow = 1'b0;
	endtask
	task t_unb;
		run(3'h5, '{16'h0900, 16'h0280});
		run(3'h2, '{16'h2400, 16'h1234, 16'h5678, 16'h0000, 16'h1234});
		run(3'h3, '{16'h2500, 16'h1234, 16'h5678, 16'h0008, 16'h0004, 16'h00AB, 16'hCDEF, 16'h0000, 16'h2000, 16'h0000, 16'h1234});
	endtask
	task t_bad;
		refuse(3'h1, 16'h0000, 32'hF0001235);
		refuse(3'h3, 16'h0009, 32'hF0001235);
		refuse(3'h0, 16'h0008, 32'h00000000);
	endtask
	// stop ends the list: later orders refused until the engine reports done
	task t_stop;
		int n;
		n = 0;
		run(3'h4, '{16'h0000});
		refuse(3'h0, 16'h0008, 32'hF0001235);
		repeat (40) begin
			@(negedge clk);
			if (list_done === 1'b1) n++;
		end
		chk(16'(n), 16'h0001);
	endtask
	task print_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// a hung handshake would stall forever; the run needs under 2000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_freeze();
		t_frame();
		t_tiled();
		t_bad();
		t_unb();
		t_stop();
		print_verdict();
	end
endmodule
bind sod_list_writer sod_list_writer_sva i_sva (.clk(clk), .reset(reset), .mem_ack(mem_ack),
	.done_evt(done_evt), .busy(busy), .req_err(req_err), .mem_wr(mem_wr),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .list_done(list_done));
